// >>> core/sdem_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module sdem_monitor import sdem_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address.
	parameter int WORD_W = 5
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Management serial port pins, open drain data.
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	// Recovery and decoder status from the same clock domain.
	input wire logic code_error,
	input wire logic recovery_event,
	input wire logic window_tick,
	input wire logic recovery_locked_flag,
	input wire logic [2:0] rate_code,
	input wire logic [1:0] signal_detect,
	// Received data path.
	input wire logic [WORD_W-1:0] rx_word,
	output logic [WORD_W-1:0] parallel_data_outputs,
	output logic link_valid
);

	// Entire module state in one record.
	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic clk_q;
		logic dat_q;
		sdem_bus_state_t bus;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic ptr_phase;
		logic is_read;
		logic nack;
		logic sda_oe;
		logic [7:0] ctrl;
		logic [7:0] evt_cfg;
		logic [15:0] thresh;
		logic [2:0] rate;
		logic [3:0] lock_stat;
		logic [15:0] run_cnt;
		logic [15:0] win_cnt;
		logic [15:0] win_fig;
		logic [7:0] rec_cnt;
		logic [7:0] loss_cnt;
		sdem_rx_state_t rx;
		logic [WORD_W-1:0] data_out;
		logic valid;
	} sdem_state_t;

	sdem_state_t s_reg; // Registered state.
	sdem_state_t s_next; // Next state.

	// Increment that sticks at the all-ones value.
	function automatic logic [15:0] sat16(input logic [15:0] v);
		sat16 = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	// Eight-bit saturating increment.
	function automatic logic [7:0] sat8(input logic [7:0] v);
		sat8 = (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	// Read decode; pure, so reading never alters any count.
	function automatic logic [7:0] rd_byte(input logic [7:0] a,
		input sdem_state_t s);
		logic [15:0] fig;
		fig = s.ctrl[FIG_SEL_BIT] ? s.win_fig : s.run_cnt;
		unique case (a)
			EVENT_CFG_ADDR: rd_byte = s.evt_cfg;
			ERR_MON_CTRL_ADDR: rd_byte = s.ctrl;
			ERR_THR_LOW_ADDR: rd_byte = s.thresh[7:0];
			ERR_THR_HIGH_ADDR: rd_byte = s.thresh[15:8];
			LINE_RATE_ADDR: rd_byte = {1'b0, s.rate, 4'h0};
			LOCK_STATUS_ADDR: rd_byte = {4'h0, s.lock_stat};
			LOSS_COUNT_ADDR: rd_byte = s.evt_cfg[EVT_SEL_BIT] ?
				s.loss_cnt : s.rec_cnt;
			ERR_COUNT_LOW_ADDR: rd_byte = fig[7:0];
			ERR_COUNT_HIGH_ADDR: rd_byte = fig[15:8];
			default: rd_byte = 8'h00;
		endcase
		return rd_byte;
	endfunction

	// All next-state logic: port, registers, counters, receive gate.
	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic sda;
		logic wr_en;
		logic err;
		logic [7:0] wa;
		logic [7:0] wd;
		logic [7:0] rb;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		sda = 1'b0;
		wr_en = 1'b0;
		err = 1'b0;
		wa = 8'h00;
		wd = 8'h00;
		rb = 8'h00;
		s_next = s_reg;
		// Two-stage synchronisers; only stage two is examined.
		s_next.clk_sync = {s_reg.clk_sync[0], smb_clk};
		s_next.dat_sync = {s_reg.dat_sync[0], smb_data_in};
		s_next.clk_q = s_reg.clk_sync[1];
		s_next.dat_q = s_reg.dat_sync[1];
		sda = s_reg.dat_sync[1];
		rise = s_reg.clk_sync[1] & ~s_reg.clk_q;
		fall = ~s_reg.clk_sync[1] & s_reg.clk_q;
		start = s_reg.clk_sync[1] & s_reg.clk_q & s_reg.dat_q & ~sda;
		stop = s_reg.clk_sync[1] & s_reg.clk_q & ~s_reg.dat_q & sda;
		// Serial port engine: bits sampled on rise, driven on fall.
		if (start) begin
			s_next.bus = SDEM_BUS_ADDR;
			s_next.bit_cnt = 4'h0;
			s_next.sda_oe = 1'b0;
		end else if (stop) begin
			s_next.bus = SDEM_BUS_IDLE;
			s_next.sda_oe = 1'b0;
		end else if (rise) begin
			unique case (s_reg.bus)
				SDEM_BUS_ADDR, SDEM_BUS_WBYTE: begin
					s_next.shift = {s_reg.shift[6:0], sda};
					s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
				end
				SDEM_BUS_RBYTE: s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
				SDEM_BUS_RACK: s_next.nack = sda;
				default: begin
				end
			endcase
		end else if (fall) begin
			rb = rd_byte(s_reg.ptr, s_reg);
			unique case (s_reg.bus)
				SDEM_BUS_ADDR: if (s_reg.bit_cnt == 4'h8) begin
					// Acknowledge only our own address.
					if (s_reg.shift[7:1] == DEV_ADDR) begin
						s_next.bus = SDEM_BUS_ADDR_ACK;
						s_next.is_read = s_reg.shift[0];
						s_next.sda_oe = 1'b1;
					end else begin
						s_next.bus = SDEM_BUS_IDLE;
					end
				end
				SDEM_BUS_ADDR_ACK: begin
					s_next.bit_cnt = 4'h0;
					if (s_reg.is_read) begin
						s_next.bus = SDEM_BUS_RBYTE;
						s_next.shift = rb;
						s_next.sda_oe = ~rb[7];
					end else begin
						s_next.bus = SDEM_BUS_WBYTE;
						s_next.ptr_phase = 1'b1;
						s_next.sda_oe = 1'b0;
					end
				end
				SDEM_BUS_WBYTE: if (s_reg.bit_cnt == 4'h8) begin
					// First byte sets the pointer, later ones write.
					s_next.bus = SDEM_BUS_WACK;
					s_next.sda_oe = 1'b1;
					s_next.ptr_phase = 1'b0;
					if (s_reg.ptr_phase) begin
						s_next.ptr = s_reg.shift;
					end else begin
						wr_en = 1'b1;
						wa = s_reg.ptr;
						wd = s_reg.shift;
						s_next.ptr = s_reg.ptr + 8'h01;
					end
				end
				SDEM_BUS_WACK: begin
					s_next.bus = SDEM_BUS_WBYTE;
					s_next.bit_cnt = 4'h0;
					s_next.sda_oe = 1'b0;
				end
				SDEM_BUS_RBYTE: if (s_reg.bit_cnt == 4'h8) begin
					s_next.bus = SDEM_BUS_RACK;
					s_next.sda_oe = 1'b0;
					s_next.ptr = s_reg.ptr + 8'h01;
				end else begin
					s_next.shift = {s_reg.shift[6:0], 1'b0};
					s_next.sda_oe = ~s_reg.shift[6];
				end
				SDEM_BUS_RACK: if (s_reg.nack) begin
					s_next.bus = SDEM_BUS_IDLE;
				end else begin
					s_next.bus = SDEM_BUS_RBYTE;
					s_next.bit_cnt = 4'h0;
					s_next.shift = rb;
					s_next.sda_oe = ~rb[7];
				end
				default: begin
				end
			endcase
		end
		// Status snapshots from the recovery logic.
		s_next.rate = recovery_locked_flag ? rate_code
			: RATE_UNLOCKED;
		s_next.lock_stat = {recovery_locked_flag, signal_detect,
			1'b0};
		// Masked coding errors are neither counted nor gate data.
		err = code_error & ~s_reg.ctrl[CODE_DIS_BIT];
		if (err) begin
			s_next.run_cnt = sat16(s_reg.run_cnt);
			s_next.win_cnt = sat16(s_reg.win_cnt);
		end
		// Window boundary latches the window figure.
		if (window_tick) begin
			s_next.win_fig = s_next.win_cnt;
			s_next.win_cnt = 16'h0000;
		end
		// Recovery events count when enabled.
		if (recovery_event && s_reg.evt_cfg[EVT_EN_BIT]) begin
			s_next.rec_cnt = sat8(s_reg.rec_cnt);
		end
		// Receive state: a new run clears the count unless accumulating.
		unique case (s_reg.rx)
			SDEM_ACQUIRE: if (recovery_locked_flag) begin
				s_next.rx = SDEM_NORMAL;
				if (!s_reg.ctrl[ACCUM_BIT]) begin
					s_next.run_cnt = 16'h0000;
				end
			end
			SDEM_NORMAL: if (!recovery_locked_flag) begin
				s_next.rx = SDEM_ACQUIRE;
			end else if (s_reg.run_cnt > s_reg.thresh &&
				!s_reg.ctrl[EXIT_DIS_BIT]) begin
				s_next.rx = SDEM_HALTED;
				if (s_reg.evt_cfg[EVT_EN_BIT]) begin
					s_next.loss_cnt = sat8(s_reg.loss_cnt);
				end
			end
			SDEM_HALTED: if (!recovery_locked_flag) begin
				s_next.rx = SDEM_ACQUIRE;
			end else if (s_reg.ctrl[CLEAR_BIT]) begin
				s_next.rx = SDEM_NORMAL;
			end
			default: s_next.rx = SDEM_ACQUIRE;
		endcase
		// Clear control zeros current and previous figures.
		if (s_reg.ctrl[CLEAR_BIT]) begin
			s_next.run_cnt = 16'h0000;
			s_next.win_cnt = 16'h0000;
			s_next.win_fig = 16'h0000;
		end
		// Event counter resets.
		if (s_reg.evt_cfg[EVT_RST_CDR_BIT]) begin
			s_next.rec_cnt = 8'h00;
		end
		if (s_reg.evt_cfg[EVT_RST_DATA_BIT]) begin
			s_next.loss_cnt = 8'h00;
		end
		// Register writes from the port take priority.
		if (wr_en) begin
			unique case (wa)
				EVENT_CFG_ADDR: s_next.evt_cfg = {4'h0, wd[3:0]};
				ERR_MON_CTRL_ADDR: s_next.ctrl = {3'h0, wd[4:0]};
				ERR_THR_LOW_ADDR: s_next.thresh[7:0] = wd;
				ERR_THR_HIGH_ADDR: s_next.thresh[15:8] = wd;
				LOSS_COUNT_ADDR: if (s_reg.evt_cfg[EVT_SEL_BIT]) begin
					s_next.loss_cnt = wd;
				end else begin
					s_next.rec_cnt = wd;
				end
				ERR_COUNT_LOW_ADDR: s_next.run_cnt[7:0] = wd;
				ERR_COUNT_HIGH_ADDR: s_next.run_cnt[15:8] = wd;
				default: begin
				end
			endcase
		end
		// Data leaves only while the link stands in its steady state.
		s_next.valid = (s_reg.rx == SDEM_NORMAL);
		s_next.data_out = (s_reg.rx == SDEM_NORMAL) ? rx_word
			: '0;
	end

	// State register with synchronous reset.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.clk_sync <= 2'h3;
			s_reg.dat_sync <= 2'h3;
			s_reg.clk_q <= 1'b1;
			s_reg.dat_q <= 1'b1;
			s_reg.bus <= SDEM_BUS_IDLE;
			s_reg.ctrl <= ERR_MON_CTRL_RST;
			s_reg.evt_cfg <= EVENT_CFG_RST;
			s_reg.thresh <= {ERR_THR_HIGH_RST, ERR_THR_LOW_RST};
			s_reg.rate <= RATE_UNLOCKED;
			s_reg.rx <= SDEM_ACQUIRE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs come straight from the state record, save the data pin output, tied low.
	assign smb_data_out = 1'b0;
	assign smb_data_oe = s_reg.sda_oe;
	assign parallel_data_outputs = s_reg.data_out;
	assign link_valid = s_reg.valid;

endmodule

`default_nettype wire

// >>> core/sdem_pkg.sv
package sdem_pkg;

	// Register offsets on the management serial port.
	localparam logic [7:0] EVENT_CFG_ADDR = 8'h2B;
	localparam logic [7:0] ERR_MON_CTRL_ADDR = 8'h2D;
	localparam logic [7:0] ERR_THR_LOW_ADDR = 8'h2E;
	localparam logic [7:0] ERR_THR_HIGH_ADDR = 8'h2F;
	localparam logic [7:0] LINE_RATE_ADDR = 8'h3B;
	localparam logic [7:0] LOCK_STATUS_ADDR = 8'h3C;
	localparam logic [7:0] LOSS_COUNT_ADDR = 8'h3D;
	localparam logic [7:0] ERR_COUNT_LOW_ADDR = 8'h3E;
	localparam logic [7:0] ERR_COUNT_HIGH_ADDR = 8'h3F;

	// Field positions of the error monitor control register.
	localparam int ACCUM_BIT = 4;
	localparam int CODE_DIS_BIT = 3;
	localparam int CLEAR_BIT = 2;
	localparam int FIG_SEL_BIT = 1;
	localparam int EXIT_DIS_BIT = 0;

	// Field positions of the event configuration register.
	localparam int EVT_SEL_BIT = 3;
	localparam int EVT_RST_CDR_BIT = 2;
	localparam int EVT_RST_DATA_BIT = 1;
	localparam int EVT_EN_BIT = 0;

	// Field positions of the status registers.
	localparam int RATE_LSB = 4;
	localparam int LOCK_BIT = 3;
	localparam int SIG1_BIT = 2;
	localparam int SIG0_BIT = 1;

	// Reset values.
	localparam logic [7:0] ERR_MON_CTRL_RST = 8'h00;
	localparam logic [7:0] EVENT_CFG_RST = 8'h00;
	localparam logic [7:0] ERR_THR_LOW_RST = 8'h10;
	localparam logic [7:0] ERR_THR_HIGH_RST = 8'h00;
	localparam logic [2:0] RATE_UNLOCKED = 3'h7;

	// Line rate codes.
	localparam logic [2:0] RATE_270M = 3'h1;
	localparam logic [2:0] RATE_1G485 = 3'h3;
	localparam logic [2:0] RATE_2G97 = 3'h6;

	// Receive monitor states, Gray coded along acquire, normal, halted.
	typedef enum logic [1:0] {
		SDEM_ACQUIRE = 2'h0,
		SDEM_NORMAL = 2'h1,
		SDEM_HALTED = 2'h3
	} sdem_rx_state_t;

	// Management port states, Gray coded along a transfer.
	typedef enum logic [2:0] {
		SDEM_BUS_IDLE = 3'h0,
		SDEM_BUS_ADDR = 3'h1,
		SDEM_BUS_ADDR_ACK = 3'h3,
		SDEM_BUS_WBYTE = 3'h2,
		SDEM_BUS_WACK = 3'h6,
		SDEM_BUS_RBYTE = 3'h7,
		SDEM_BUS_RACK = 3'h5
	} sdem_bus_state_t;

endpackage

// >>> tb/sdem_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host on the two-wire management port; the data line has a pull-up.
module sdem_host_model #(
	parameter logic [6:0] DEV = 7'h2A
) (
	input wire logic ref_clk,
	output logic scl,
	output logic sda_o,
	input wire logic sda
);
	// Both lines idle high.
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	// One clock phase, above the four-cycle minimum.
	task automatic ph();
		repeat (5) @(negedge ref_clk);
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		sda_o = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_o = 1'b0;
		ph();
		scl = 1'b0;
		ph();
	endtask
	// One bit; the line is sampled in the high phase.
	task automatic bit_x(input logic b, output logic r);
		sda_o = b;
		ph();
		scl = 1'b1;
		ph();
		r = sda;
		scl = 1'b0;
		ph();
	endtask
	// A byte msb first, then the ninth bit.
	task automatic xfer(input logic [7:0] d, input logic n,
		output logic [7:0] r);
		logic k;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(n, k);
	endtask
	// Stop: data rises while the clock is high.
	task automatic stop();
		sda_o = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_o = 1'b1;
		ph();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({DEV, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		xfer(d, 1'b1, r);
		stop();
	endtask
	// Read of one byte; the final not-acknowledge ends it.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({DEV, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		start();
		xfer({DEV, 1'b1}, 1'b1, r);
		xfer(8'hFF, 1'b1, d);
		stop();
	endtask
endmodule
`default_nettype wire

// >>> tb/sdem_monitor_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Pin-level timing relations of the monitor.
module sdem_monitor_sva #(
	parameter int WORD_W = 5
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Management port.
	input wire logic smb_clk,
	input wire logic smb_data_in,
	input wire logic smb_data_out,
	input wire logic smb_data_oe,
	// Status and data.
	input wire logic code_error,
	input wire logic recovery_event,
	input wire logic window_tick,
	input wire logic recovery_locked_flag,
	input wire logic [2:0] rate_code,
	input wire logic [1:0] signal_detect,
	input wire logic [WORD_W-1:0] rx_word,
	input wire logic [WORD_W-1:0] parallel_data_outputs,
	input wire logic link_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A held acknowledge or data bit.
	sequence oe_held;
		smb_data_oe [*4];
	endsequence
	// Lock rises and stays for one more cycle.
	sequence lock_up;
		$rose(recovery_locked_flag) ##1 recovery_locked_flag;
	endsequence
	a_data_pass: assert property (link_valid |->
		parallel_data_outputs == $past(rx_word))
		else $error("data output is not the last word");
	a_data_idle: assert property (!link_valid |->
		parallel_data_outputs == '0)
		else $error("data output not zero while halted");
	a_lock_valid: assert property (lock_up |=> link_valid)
		else $error("link valid late after lock");
	a_unlock_drop: assert property (!recovery_locked_flag [*3] |->
		!link_valid)
		else $error("link valid without lock");
	a_valid_rise: assert property ($rose(link_valid) |->
		$past(recovery_locked_flag, 2))
		else $error("link valid rose without lock");
	a_oe_phase: assert property ($changed(smb_data_oe) |-> !smb_clk)
		else $error("data pin changed while clock high");
	a_oe_hold: assert property ($rose(smb_data_oe) |-> oe_held)
		else $error("data pin pull too short");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=>
		!link_valid && !smb_data_oe && parallel_data_outputs == '0)
		else $error("outputs active after reset");
endmodule
bind sdem_monitor sdem_monitor_sva #(.WORD_W(WORD_W)) i_sva (.*);
`default_nettype wire

// >>> tb/test_sdi_rx_error_monitor_status.sv
`timescale 1ns/100ps
`default_nettype none
// Drives the monitor through its port and status inputs.
module test_sdi_rx_error_monitor_status import sdem_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic sda_o;
	logic oe;
	logic sda_out;
	logic code_error = 1'b0;
	logic rec_ev = 1'b0;
	logic lock = 1'b0;
	logic win_tick = 1'b0;
	logic [2:0] rate = 3'h0;
	logic [1:0] sd = 2'h0;
	logic [4:0] rx_word = 5'h00;
	logic [4:0] pdo;
	logic link_valid;
	logic [7:0] rd_data;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] ra [8] = '{ERR_MON_CTRL_ADDR, ERR_THR_LOW_ADDR,
		ERR_THR_HIGH_ADDR, LINE_RATE_ADDR, LOCK_STATUS_ADDR,
		LOSS_COUNT_ADDR, ERR_COUNT_LOW_ADDR, 8'h30};
	logic [7:0] rv [8] = '{ERR_MON_CTRL_RST, ERR_THR_LOW_RST,
		ERR_THR_HIGH_RST, {1'b0, RATE_UNLOCKED, 4'h0}, 8'h00, 8'h00,
		8'h00, 8'h00};
	// Open-drain data line with pull-up.
	wire logic sda = sda_o & ~oe;
	always #5 ref_clk = ~ref_clk;
	// A fresh word every cycle.
	always @(negedge ref_clk) rx_word <= rx_word + 5'h01;
	// Cuts a hang short.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			results();
		end
	end
	sdem_monitor i_dut (.ref_clk(ref_clk), .rst(rst), .smb_clk(scl),
		.smb_data_in(sda), .smb_data_out(sda_out), .smb_data_oe(oe),
		.code_error(code_error), .recovery_event(rec_ev),
		.window_tick(win_tick), .recovery_locked_flag(lock),
		.rate_code(rate), .signal_detect(sd), .rx_word(rx_word),
		.parallel_data_outputs(pdo), .link_valid(link_valid));
	sdem_host_model i_host (.ref_clk(ref_clk), .scl(scl), .sda_o(sda_o),
		.sda(sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, rd_data);
		chk(rd_data, e);
	endtask
	// Single-cycle pulses on the chosen input.
	task automatic pulse(input int n, input logic ev);
		repeat (n) begin
			@(negedge ref_clk) {rec_ev, code_error} = ev ? 2'b10 : 2'b01;
			@(negedge ref_clk) {rec_ev, code_error} = 2'b00;
		end
	endtask
	task automatic relock();
		@(negedge ref_clk) lock = 1'b0;
		repeat (4) @(negedge ref_clk);
		lock = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		foreach (ra[i]) rc(ra[i], rv[i]);
		rate = RATE_1G485;
		sd = 2'b10;
		lock = 1'b1;
		repeat (4) @(negedge ref_clk);
		rc(LINE_RATE_ADDR, {1'b0, RATE_1G485, 4'h0});
		rc(LOCK_STATUS_ADDR, 8'h0C);
		i_host.wr(LINE_RATE_ADDR, 8'hFF);
		rc(LINE_RATE_ADDR, {1'b0, RATE_1G485, 4'h0});
		i_host.wr(ERR_THR_HIGH_ADDR, 8'h01);
		rc(ERR_THR_HIGH_ADDR, 8'h01);
		i_host.wr(ERR_THR_HIGH_ADDR, 8'h00);
		i_host.wr(ERR_THR_LOW_ADDR, 8'h03);
		pulse(3, 1'b0);
		chk({7'h00, link_valid}, 8'h01);
		rc(ERR_COUNT_LOW_ADDR, 8'h03);
		pulse(1, 1'b0);
		repeat (3) @(negedge ref_clk);
		chk({7'h00, link_valid}, 8'h00);
		chk({3'h0, pdo}, 8'h00);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h04);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h00);
		rc(ERR_COUNT_LOW_ADDR, 8'h00);
		chk({7'h00, link_valid}, 8'h01);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h01);
		pulse(5, 1'b0);
		chk({7'h00, link_valid}, 8'h01);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h09);
		pulse(2, 1'b0);
		rc(ERR_COUNT_LOW_ADDR, 8'h05);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h11);
		relock();
		rc(ERR_COUNT_LOW_ADDR, 8'h05);
		// The window holds five counted errors; two more, then it closes.
		pulse(2, 1'b0);
		@(negedge ref_clk) win_tick = 1'b1;
		@(negedge ref_clk) win_tick = 1'b0;
		pulse(1, 1'b0);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h13);
		rc(ERR_COUNT_LOW_ADDR, 8'h07);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h11);
		rc(ERR_COUNT_LOW_ADDR, 8'h08);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h17);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h13);
		rc(ERR_COUNT_LOW_ADDR, 8'h00);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h01);
		pulse(1, 1'b0);
		relock();
		rc(ERR_COUNT_LOW_ADDR, 8'h00);
		i_host.wr(EVENT_CFG_ADDR, 8'h01);
		pulse(2, 1'b1);
		rc(LOSS_COUNT_ADDR, 8'h02);
		// Masked errors leave the link alone; counted ones halt it.
		i_host.wr(EVENT_CFG_ADDR, 8'h09);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h08);
		pulse(4, 1'b0);
		chk({7'h00, link_valid}, 8'h01);
		i_host.wr(ERR_MON_CTRL_ADDR, 8'h00);
		pulse(4, 1'b0);
		rc(LOSS_COUNT_ADDR, 8'h01);
		chk({7'h00, link_valid}, 8'h00);
		results();
	end
endmodule
`default_nettype wire
